// >>> rtl/tqo_pkg.sv
// Package: constants, carriers and helpers of the two-channel torque-off supervisor
package tqo_pkg;
  // Timing of the core clock, the safety monitoring cycle and input sampling
  localparam int CLK_PERIOD_NS = 10;
  localparam int MON_CYCLE_NS = 4000000;
  localparam int IO_SAMPLE_NS = 4000000;
  localparam int MON_CLKS = MON_CYCLE_NS / CLK_PERIOD_NS;
  localparam int IO_CLKS = IO_SAMPLE_NS / CLK_PERIOD_NS;
  // Switch-off path test interval: 8 h counted in 4 ms monitoring cycles
  localparam int TEST_TICKS = 7200000;
  // Register byte addresses
  localparam logic [7:0] ADDR_CU_EN = 8'h00;
  localparam logic [7:0] ADDR_MM_EN = 8'h04;
  localparam logic [7:0] ADDR_CU_DLY = 8'h08;
  localparam logic [7:0] ADDR_MM_DLY = 8'h0C;
  localparam logic [7:0] ADDR_CU_DISC = 8'h10;
  localparam logic [7:0] ADDR_MM_DISC = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_COMP = 8'h1C;
  localparam logic [7:0] ADDR_CU_STAT = 8'h20;
  localparam logic [7:0] ADDR_MM_STAT = 8'h24;
  localparam logic [7:0] ADDR_COMB_STAT = 8'h28;
  localparam logic [7:0] ADDR_GROUP_STAT = 8'h2C;
  localparam logic [7:0] ADDR_EVENT = 8'h30;
  // Enable word bits
  localparam int EN_TERM = 0;
  localparam int EN_EXT = 2;
  localparam int EN_BUS = 3;
  // Control register bits
  localparam int CTRL_BRAKE = 0;
  localparam int CTRL_MSG = 1;
  // Reset values
  localparam logic [3:0] RST_EN = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_DELAY = 3'b010,
    CH_OFF = 3'b100
  } tqo_chan_state_type;

  // Selection requests of one channel from the three possible sources
  typedef struct packed {
    logic term;
    logic ext;
    logic bus;
  } tqo_sel_type;

  // State seen from outside one channel
  typedef struct packed {
    logic off;
    logic dly;
    logic fault;
    logic silent;
  } tqo_chan_stat_type;

  // Effective selection; the enable word is the AND of both channels' words
  function automatic logic sel_of(input logic [3:0] en, input tqo_sel_type s);
    sel_of = (en[EN_TERM] & s.term) | (en[EN_EXT] & ~en[EN_BUS] & s.ext) |
             (en[EN_EXT] & en[EN_BUS] & s.bus);
  endfunction : sel_of

  // Status word layout shared by both channels
  function automatic logic [31:0] stat_word(input tqo_chan_stat_type c,
      input logic stop_f, input logic stop_a, input logic pon, input logic s1en);
    stat_word = {25'h0, s1en, pon, stop_a, stop_f, c.fault, c.dly, c.off};
  endfunction : stat_word
endpackage : tqo_pkg

// >>> rtl/tqo_tick.sv
// Periodic one-cycle tick generator
`timescale 1ns/100ps
module tqo_tick #(
  parameter int N = 400000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Tick
  output logic tick_o
);
  localparam int W = $clog2(N + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tqo_tick_type;
  tqo_tick_type q_ff, nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick = (q_ff.cnt == W'(N - 1));
    nxt_q.cnt = nxt_q.tick ? '0 : q_ff.cnt + W'(1);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tick_o = q_ff.tick;
endmodule : tqo_tick

// >>> rtl/tqo_chan.sv
// One monitoring channel: torque-off state, stop-one delay, discrepancy check
`timescale 1ns/100ps
module tqo_chan import tqo_pkg::*; #(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Monitoring cycle and selection
  input wire logic tick_i,
  input wire logic sel_i,
  input wire logic peer_sel_i,
  input wire logic stop_one_en_i,
  input wire logic [DW-1:0] delay_i,
  input wire logic [DW-1:0] disc_i,
  // Channel state
  output tqo_chan_stat_type stat_o
);
  typedef struct packed {
    tqo_chan_state_type st;
    logic [DW-1:0] dcnt;
    logic [DW-1:0] xcnt;
    logic fault;
    logic silent;
  } tqo_chst_type;
  tqo_chst_type q_ff, nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.silent = 1'b0;
    if (tick_i) begin
      if (sel_i != peer_sel_i) begin
        if (q_ff.xcnt != '1) begin
          nxt_q.xcnt = q_ff.xcnt + DW'(1);
        end
        if (q_ff.xcnt >= disc_i) begin
          nxt_q.fault = 1'b1;
        end
      end else begin
        nxt_q.silent = (q_ff.xcnt != '0) & ~q_ff.fault;
        nxt_q.xcnt = '0;
        if (!sel_i) begin
          nxt_q.fault = 1'b0;
        end
      end
      unique case (q_ff.st)
        CH_IDLE: begin
          if (q_ff.fault) begin
            nxt_q.st = CH_OFF;
          end else if (sel_i && stop_one_en_i) begin
            nxt_q.st = CH_DELAY;
            nxt_q.dcnt = delay_i;
          end else if (sel_i) begin
            nxt_q.st = CH_OFF;
          end
        end
        CH_DELAY: begin
          if (q_ff.dcnt <= DW'(1) || q_ff.fault) begin
            nxt_q.st = CH_OFF;
          end
          nxt_q.dcnt = q_ff.dcnt - DW'(1);
        end
        CH_OFF: begin
          if (!sel_i && !q_ff.fault) begin
            nxt_q.st = CH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= '{st: CH_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign stat_o = '{off: q_ff.st == CH_OFF, dly: q_ff.st == CH_DELAY,
                    fault: q_ff.fault, silent: q_ff.silent};

  property p_expiry;
    @(posedge core_clk_i) disable iff (rst_i)
    q_ff.st == CH_DELAY && tick_i && q_ff.dcnt == DW'(1) |=> q_ff.st == CH_OFF;
  endproperty
  a_expiry: assert property (p_expiry) else $error("stop-one expiry missed");

  property p_direct;
    @(posedge core_clk_i) disable iff (rst_i)
    q_ff.st == CH_IDLE && tick_i && sel_i && stop_one_en_i && !q_ff.fault
      |=> q_ff.st == CH_DELAY;
  endproperty
  a_direct: assert property (p_direct) else $error("direct off with delay set");

  property p_release;
    @(posedge core_clk_i) disable iff (rst_i)
    q_ff.st == CH_OFF && tick_i && !sel_i && !q_ff.fault |=> q_ff.st == CH_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("deselect not released");
endmodule : tqo_chan

// >>> rtl/tqo_top.sv
// Two-channel torque-off and timed stop-one supervisor with AHB-Lite registers
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module tqo_top import tqo_pkg::*; #(
  parameter int DW = 16,
  parameter int TW = 24,
  parameter int MON_N = MON_CLKS,
  parameter int IO_N = IO_CLKS,
  parameter int TEST_N = TEST_TICKS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Selection requests per channel
  input wire tqo_sel_type cu_sel_i,
  input wire tqo_sel_type mm_sel_i,
  // Drive control inputs
  input wire logic startup_done_i,
  input wire logic drive_enable_i,
  input wire logic on_off_input_i,
  // Drive outputs
  output logic cu_pulse_off_o,
  output logic mm_pulse_off_o,
  output logic brake_apply_o,
  output logic fast_stop_ramp_o,
  output logic drive_on_o,
  output logic safety_fault_o,
  output logic test_due_o
);
  typedef struct packed {
    logic [3:0] cu_en;
    logic [3:0] mm_en;
    logic [DW-1:0] cu_dly;
    logic [DW-1:0] mm_dly;
    logic [DW-1:0] cu_disc;
    logic [DW-1:0] mm_disc;
    logic brake_cfg;
    logic msg_alarm;
    logic [1:0] sel;
    logic up;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic rdy;
    logic pon_dis;
    logic drive_on;
    logic onoff_q;
    logic stop_f;
    logic stop_a;
    logic ev_silent;
    logic comp_on;
    logic comp_ref;
    logic [TW-1:0] tcnt;
    logic tdue;
    logic cu_off;
    logic mm_off;
    logic brake;
    logic ramp;
    logic fault;
  } tqo_top_type;
  tqo_top_type q_ff, nxt_q;

  logic mon_tick;
  logic io_tick;
  tqo_chan_stat_type ch_cu;
  tqo_chan_stat_type ch_mm;
  logic [3:0] en_both;
  logic to_en;
  logic s1_en;
  logic any_off;
  logic act;
  logic released;
  logic take;
  logic [31:0] rd;
  logic [31:0] cu_word;
  logic [31:0] mm_word;

  tqo_tick #(.N(MON_N)) u_mon_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(mon_tick)
  );

  tqo_tick #(.N(IO_N)) u_io_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(io_tick)
  );

  tqo_chan #(.DW(DW)) u_cu_chan (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_i(mon_tick),
    .sel_i(q_ff.sel[0]),
    .peer_sel_i(q_ff.sel[1]),
    .stop_one_en_i(s1_en),
    .delay_i(q_ff.cu_dly),
    .disc_i(q_ff.cu_disc),
    .stat_o(ch_cu)
  );

  tqo_chan #(.DW(DW)) u_mm_chan (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_i(mon_tick),
    .sel_i(q_ff.sel[1]),
    .peer_sel_i(q_ff.sel[0]),
    .stop_one_en_i(s1_en),
    .delay_i(q_ff.mm_dly),
    .disc_i(q_ff.mm_disc),
    .stat_o(ch_mm)
  );

  always_comb begin
    nxt_q = q_ff;
    en_both = q_ff.cu_en & q_ff.mm_en;
    to_en = en_both[EN_TERM] | en_both[EN_EXT];
    s1_en = to_en & (q_ff.cu_dly != '0) & (q_ff.mm_dly != '0);
    any_off = ch_cu.off | ch_mm.off;
    act = any_off | ch_cu.dly | ch_mm.dly;
    released = (q_ff.cu_off | q_ff.mm_off) & ~any_off;
    take = hsel_i & htrans_i[1] & hready_i;
    cu_word = stat_word(ch_cu, q_ff.stop_f, q_ff.stop_a, q_ff.pon_dis, s1_en);
    mm_word = stat_word(ch_mm, q_ff.stop_f, q_ff.stop_a, q_ff.pon_dis, s1_en);

    nxt_q.up = q_ff.up | startup_done_i;
    if (io_tick) begin
      // bit 3, with bit 2 set, picks the bus input in place of the external input
      nxt_q.sel[0] = q_ff.up & sel_of(en_both, cu_sel_i);
      nxt_q.sel[1] = q_ff.up & sel_of(en_both, mm_sel_i);
    end

    case (haddr_i)
      ADDR_CU_EN: rd = {28'h0, q_ff.cu_en};
      ADDR_MM_EN: rd = {28'h0, q_ff.mm_en};
      ADDR_CU_DLY: rd = 32'(q_ff.cu_dly);
      ADDR_MM_DLY: rd = 32'(q_ff.mm_dly);
      ADDR_CU_DISC: rd = 32'(q_ff.cu_disc);
      ADDR_MM_DISC: rd = 32'(q_ff.mm_disc);
      ADDR_CTRL: rd = {30'h0, q_ff.msg_alarm, q_ff.brake_cfg};
      ADDR_COMP: rd = {30'h0, q_ff.comp_ref, q_ff.comp_on};
      ADDR_CU_STAT: rd = cu_word;
      ADDR_MM_STAT: rd = mm_word;
      ADDR_COMB_STAT: rd = cu_word | mm_word;
      ADDR_GROUP_STAT: rd = {29'h0, act, ch_cu.off & ch_mm.off, any_off};
      ADDR_EVENT: rd = {31'h0, q_ff.ev_silent};
      default: rd = RST_WORD;
    endcase

    // Zero-wait slave: read data is fetched in the address phase
    nxt_q.rdy = 1'b1;
    nxt_q.ap_wr = take & hwrite_i;
    nxt_q.ap_addr = haddr_i;
    if (take && !hwrite_i) begin
      nxt_q.rdata = rd;
    end

    nxt_q.ev_silent = q_ff.ev_silent;
    if (q_ff.ap_wr) begin
      case (q_ff.ap_addr)
        ADDR_CU_EN: nxt_q.cu_en = hwdata_i[3:0];
        ADDR_MM_EN: nxt_q.mm_en = hwdata_i[3:0];
        ADDR_CU_DLY: nxt_q.cu_dly = hwdata_i[DW-1:0];
        ADDR_MM_DLY: nxt_q.mm_dly = hwdata_i[DW-1:0];
        ADDR_CU_DISC: nxt_q.cu_disc = hwdata_i[DW-1:0];
        ADDR_MM_DISC: nxt_q.mm_disc = hwdata_i[DW-1:0];
        ADDR_CTRL: begin
          nxt_q.brake_cfg = hwdata_i[CTRL_BRAKE];
          nxt_q.msg_alarm = hwdata_i[CTRL_MSG];
        end
        ADDR_COMP: begin
          if (act) begin
            nxt_q.comp_ref = 1'b1;
          end else begin
            nxt_q.comp_on = hwdata_i[0];
            nxt_q.comp_ref = 1'b0;
          end
        end
        ADDR_EVENT: nxt_q.ev_silent = q_ff.ev_silent & ~hwdata_i[0];
        default: nxt_q.ev_silent = q_ff.ev_silent;
      endcase
    end
    // A new event in the clearing cycle is kept
    if (q_ff.msg_alarm && (ch_cu.silent || ch_mm.silent)) begin
      nxt_q.ev_silent = 1'b1;
    end

    if (released) begin
      nxt_q.stop_f = 1'b0;
      nxt_q.stop_a = 1'b0;
    end
    if (ch_cu.fault || ch_mm.fault) begin
      nxt_q.stop_f = 1'b1;
    end
    if (q_ff.up && q_ff.cu_en != q_ff.mm_en) begin
      nxt_q.stop_a = 1'b1;
    end

    nxt_q.onoff_q = on_off_input_i;
    if (any_off) begin
      nxt_q.pon_dis = 1'b1;
    end else if (drive_enable_i && !on_off_input_i && q_ff.onoff_q) begin
      nxt_q.pon_dis = 1'b0;
    end
    if (act || q_ff.pon_dis || !drive_enable_i || !on_off_input_i) begin
      nxt_q.drive_on = 1'b0;
    end else if (on_off_input_i && !q_ff.onoff_q) begin
      nxt_q.drive_on = 1'b1;
    end

    if (released) begin
      nxt_q.tcnt = TW'(TEST_N);
      nxt_q.tdue = 1'b0;
    end else if (mon_tick) begin
      if (q_ff.tcnt == '0) begin
        nxt_q.tdue = 1'b1;
      end else begin
        nxt_q.tcnt = q_ff.tcnt - TW'(1);
      end
    end

    nxt_q.cu_off = ch_cu.off;
    nxt_q.mm_off = ch_mm.off;
    nxt_q.brake = q_ff.brake_cfg & any_off;
    nxt_q.ramp = ch_cu.dly;
    nxt_q.fault = ch_cu.fault | ch_mm.fault | q_ff.stop_a;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= '{cu_en: RST_EN, mm_en: RST_EN, tcnt: TW'(TEST_N), rdy: 1'b1,
                pon_dis: 1'b1, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign hrdata_o = q_ff.rdata;
  assign hreadyout_o = q_ff.rdy;
  assign hresp_o = 1'b0;
  assign cu_pulse_off_o = q_ff.cu_off;
  assign mm_pulse_off_o = q_ff.mm_off;
  assign brake_apply_o = q_ff.brake;
  assign fast_stop_ramp_o = q_ff.ramp;
  assign drive_on_o = q_ff.drive_on;
  assign safety_fault_o = q_ff.fault;
  assign test_due_o = q_ff.tdue;

  property p_pulse;
    @(posedge core_clk_i) disable iff (rst_i)
    ch_mm.off |=> mm_pulse_off_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulses not suppressed");

  property p_brake;
    @(posedge core_clk_i) disable iff (rst_i)
    q_ff.brake_cfg && (ch_cu.off || ch_mm.off) |=> brake_apply_o;
  endproperty
  a_brake: assert property (p_brake) else $error("brake not applied");

  property p_restart;
    @(posedge core_clk_i) disable iff (rst_i)
    !drive_on_o && !(on_off_input_i && !q_ff.onoff_q) |=> !drive_on_o;
  endproperty
  a_restart: assert property (p_restart) else $error("drive on without edge");

  property p_refuse;
    @(posedge core_clk_i) disable iff (rst_i)
    q_ff.ap_wr && q_ff.ap_addr == ADDR_COMP && act |=> $stable(q_ff.comp_on) && q_ff.comp_ref;
  endproperty
  a_refuse: assert property (p_refuse) else $error("deactivation not refused");

  property p_startup;
    @(posedge core_clk_i) disable iff (rst_i)
    !q_ff.up |=> q_ff.sel == 2'b00;
  endproperty
  a_startup: assert property (p_startup) else $error("selection before startup");

  property p_ramp;
    @(posedge core_clk_i) disable iff (rst_i)
    fast_stop_ramp_o |-> $past(ch_cu.dly);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not from one channel");

  property p_decode;
    @(posedge core_clk_i) disable iff (rst_i)
    io_tick && q_ff.up && en_both == 4'h0 |=> q_ff.sel == 2'b00;
  endproperty
  a_decode: assert property (p_decode) else $error("selection while disabled");

  property p_reload;
    @(posedge core_clk_i) disable iff (rst_i)
    released |=> q_ff.tcnt == TW'(TEST_N) && !test_due_o;
  endproperty
  a_reload: assert property (p_reload) else $error("test timer not reloaded");

  property p_stop_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    released && !ch_cu.fault && !ch_mm.fault |=> !q_ff.stop_f;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop command not cleared");
endmodule : tqo_top

// >>> verification/tqo_term_model.sv
// Safety terminal model driving the selection inputs of both channels
`timescale 1ns/100ps
module tqo_term_model import tqo_pkg::*; (
  // Clock
  input wire logic core_clk_i,
  // Commands from the bench
  input wire logic req_i,
  input wire logic skew_i,
  input wire logic [1:0] src_i,
  // Selection terminals
  output tqo_sel_type cu_sel_o,
  output tqo_sel_type mm_sel_o
);
  logic [2:0] hot;
  assign hot = {src_i == 2'h0, src_i == 2'h1, src_i == 2'h2};
  // both inputs together
  // A skew holds the power-side input back to provoke a discrepancy
  always_ff @(posedge core_clk_i) begin
    cu_sel_o <= hot & {3{req_i}};
    mm_sel_o <= hot & {3{req_i & ~skew_i}};
  end
endmodule : tqo_term_model

// >>> verification/safe_torque_off_stop1_control_tb.sv
// Self-checking bench of the two-channel torque-off supervisor
`timescale 1ns/100ps
module safe_torque_off_stop1_control_tb import tqo_pkg::*;;
  localparam int MN = 20;
  // Worst selection response is IO_N + MON_N + 2 clocks
  localparam int RSP = 44;
  logic clk, rst, hsel, hwrite, hready, hresp, startup, drive_en, on_off;
  logic req, skew, cu_po, mm_po, brake, ramp, drive_on, fault, test_due, seen;
  logic [1:0] htrans, src;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, r, d;
  logic [3:0] en_tab [6];
  logic [1:0] src_tab [6];
  logic exp_tab [6];
  tqo_sel_type cu_sel, mm_sel;
  int n_fail, n_compared, cyc;
  int seed = 32'hA477E0C1;

  tqo_top #(.MON_N(MN), .IO_N(MN), .TEST_N(50)) u_dut (
    .core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cu_sel_i(cu_sel),
    .mm_sel_i(mm_sel), .startup_done_i(startup), .drive_enable_i(drive_en),
    .on_off_input_i(on_off), .cu_pulse_off_o(cu_po), .mm_pulse_off_o(mm_po),
    .brake_apply_o(brake), .fast_stop_ramp_o(ramp), .drive_on_o(drive_on),
    .safety_fault_o(fault), .test_due_o(test_due));

  tqo_term_model u_term (.core_clk_i(clk), .req_i(req), .skew_i(skew), .src_i(src),
    .cu_sel_o(cu_sel), .mm_sel_o(mm_sel));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic chk1(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk1

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk32

  // Single word transfer; the design answers without wait states
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    // Data phase ends at this edge; read data still stands here
    r = hrdata;
  endtask : ahb

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic both_off(input logic e);
    chk1(cu_po, e, "cu pulse off");
    chk1(mm_po, e, "mm pulse off");
  endtask : both_off

  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 44'h0};
    {startup, drive_en, on_off, req, skew, src} = {5'h04, 2'h0};
    en_tab = '{4'h4, 4'h4, 4'h4, 4'hC, 4'hC, 4'hC};
    src_tab = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    exp_tab = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    wt(6);
    rst <= 1'b0;
    wt(2);
    ahb(1'b0, ADDR_COMB_STAT, 32'h0);
    chk32(r, 32'h0000_0020, "combined status"); // reset status
    ahb(1'b0, 8'h3C, 32'h0);
    chk32(r, 32'h0000_0000, "unmapped read"); // unmapped reads zero
    chk1(hresp, 1'b0, "response"); // always okay
    ahb(1'b1, ADDR_CU_EN, 32'h1);
    ahb(1'b1, ADDR_MM_EN, 32'h1);
    ahb(1'b1, ADDR_CTRL, 32'h1);
    ahb(1'b1, ADDR_CU_DISC, 32'h2);
    ahb(1'b1, ADDR_MM_DISC, 32'h2);
    req <= 1'b1;
    wt(RSP);
    both_off(1'b0); // ignored before startup
    req <= 1'b0;
    startup <= 1'b1;
    wt(RSP);
    req <= 1'b1;
    wt(RSP);
    both_off(1'b1); // off in time
    chk1(brake, 1'b1, "brake applied"); // brake request
    ahb(1'b0, ADDR_CU_STAT, 32'h0);
    chk32(r, 32'h0000_0021, "cu status"); // channel status
    ahb(1'b0, ADDR_GROUP_STAT, 32'h0);
    chk1(r[1], 1'b1, "group both off"); // group status
    ahb(1'b1, ADDR_COMP, 32'h0);
    ahb(1'b0, ADDR_COMP, 32'h0);
    chk1(r[1], 1'b1, "deactivation refused"); // refusal flagged
    // Power-side input drops for one sampling period only
    ahb(1'b1, ADDR_CTRL, 32'h3);
    skew <= 1'b1;
    wt(MN);
    skew <= 1'b0;
    wt(RSP);
    ahb(1'b0, ADDR_EVENT, 32'h0);
    chk1(r[0], 1'b1, "silent reselect event"); // message when enabled
    ahb(1'b1, ADDR_EVENT, 32'h1);
    ahb(1'b0, ADDR_EVENT, 32'h0);
    chk1(r[0], 1'b0, "event cleared"); // write one clears
    chk1(fault, 1'b0, "no fault on short skew"); // within discrepancy time
    req <= 1'b0;
    wt(RSP);
    both_off(1'b0); // pulses released
    chk1(brake, 1'b0, "brake withdrawn"); // brake released
    chk1(drive_on, 1'b0, "no self restart"); // stays off
    chk1(test_due, 1'b0, "test timer"); // reloaded on release
    drive_en <= 1'b1;
    on_off <= 1'b0;
    wt(3);
    on_off <= 1'b1;
    wt(3);
    chk1(drive_on, 1'b1, "restart"); // falling then rising edge
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, ADDR_CU_EN, {28'h0, en_tab[i]});
      ahb(1'b1, ADDR_MM_EN, {28'h0, en_tab[i]});
      src <= src_tab[i];
      req <= 1'b1;
      wt(RSP);
      both_off(exp_tab[i]); // source enables
      req <= 1'b0;
      wt(RSP);
    end
    src <= 2'h0;
    ahb(1'b1, ADDR_CU_EN, 32'h1);
    ahb(1'b1, ADDR_MM_EN, 32'h1);
    req <= 1'b1;
    skew <= 1'b1;
    wt(RSP);
    chk1(cu_po, 1'b1, "cu alone off"); // own selection
    wt(4 * MN);
    chk1(fault, 1'b1, "discrepancy fault"); // disagreement
    both_off(1'b1); // forced off
    ahb(1'b0, ADDR_MM_STAT, 32'h0);
    chk1(r[2], 1'b1, "mm discrepancy bit"); // channel fault status
    req <= 1'b0;
    skew <= 1'b0;
    // Fault clears one cycle, release and stop-A clear the next
    wt(2 * RSP);
    chk1(fault, 1'b0, "fault cleared"); // cleared on deselect
    d = 32'd3 + ($unsigned($random(seed)) % 3);
    ahb(1'b1, ADDR_CU_DLY, d);
    req <= 1'b1;
    wt(RSP);
    chk1(ramp, 1'b0, "one-sided delay"); // needs both delays
    both_off(1'b1); // direct off
    req <= 1'b0;
    wt(RSP);
    ahb(1'b1, ADDR_MM_DLY, d);
    req <= 1'b1;
    wt(RSP);
    chk1(ramp, 1'b1, "ramp running"); // fast stop ramp
    both_off(1'b0); // no direct off
    wt(d * MN);
    both_off(1'b1); // off after delay
    chk1(ramp, 1'b0, "ramp ended"); // ramp ends
    req <= 1'b0;
    wt(RSP);
    req <= 1'b1;
    wt(RSP);
    req <= 1'b0;
    seen = 1'b0;
    repeat (d * MN + 2 * RSP) begin
      @(posedge clk);
      if (cu_po === 1'b1)
        seen = 1'b1;
    end
    chk1(seen, 1'b1, "off at expiry"); // timer completes
    both_off(1'b0); // released afterwards
    wt(52 * MN);
    chk1(test_due, 1'b1, "test due"); // interval elapsed
    report_and_stop();
  end
endmodule : safe_torque_off_stop1_control_tb
